// *** include/wake_defines.svh ***
// offsets, field positions, masks and reset values of the wake register page
`ifndef WAKE_DEFINES_SVH
`define WAKE_DEFINES_SVH

// ****************************************************
// management access
// ****************************************************
`define MGMT_PAGE_SELECT_REG 5'h1F
`define MGMT_REG_NUMBER_REG 5'h11
`define MGMT_REG_DATA_REG 5'h12
`define WAKE_PAGE_NUMBER 16'h0320

// ****************************************************
// register numbers within the wake page
// ****************************************************
`define WAKE_CONTROL_IDX 16'h0001
`define WAKE_FILTER_ENABLE_IDX 16'h0002
`define WAKE_CAUSE_STATUS_IDX 16'h0003
`define STATION_LOW_LO_IDX 16'h0010
`define STATION_LOW_HI_IDX 16'h0011
`define STATION_HIGH_LO_IDX 16'h0012
`define STATION_HIGH_HI_IDX 16'h0013

// ****************************************************
// wake_filter_enable fields
// ****************************************************
`define LINK_CHANGE_WAKE 0
`define MAGIC_PACKET_WAKE 1
`define EXACT_MATCH_WAKE 2
`define MULTICAST_WAKE 3
`define BROADCAST_WAKE 4
`define ARP_IPV4_WAKE 5
`define DIRECTED_IPV4_WAKE 6
`define DIRECTED_IPV6_WAKE 7
`define FILTER_ENABLE_RSVD 8
`define FLEXIBLE_FILTER_4 9
`define FLEXIBLE_FILTER_5 10
`define IGNORE_MANAGEABILITY_PACKETS 11
`define FLEXIBLE_FILTER_0 12
`define FILTER_ENABLE_WRITE_MASK 16'hFEFF

// ****************************************************
// wake_cause_status flexible positions
// ****************************************************
`define STATUS_FLEX_4 8
`define STATUS_FLEX_6 10
`define STATUS_FLEX_0 12

// ****************************************************
// wake control fields
// ****************************************************
`define CTRL_APM_ENABLE 0
`define POWER_EVENT_FLAG 2
`define CTRL_LINK_WAKE_ENABLE 4
`define LINK_WAKE_OVERRIDE 5
`define CTRL_FLEXIBLE_FILTER_6 14
`define CTRL_STORE_MASK 16'hC03B

// ****************************************************
// station address fields and reset values
// ****************************************************
`define ADDRESS_COMPARE_VALID 15
`define STATION_HIGH_HI_MASK 16'h8000
`define ZERO_WORD 16'h0000

`endif

// *** include/wake_pkg.sv ***
// types shared by the wake filter control and status block
package wake_pkg;

  typedef struct packed {
    logic [47:0] dest_addr;
    logic manageability;
    logic [15:0] match;
  } rx_event_t;

  typedef struct packed {
    logic write;
    logic [4:0] reg_num;
    logic [15:0] wdata;
  } mgmt_req_t;

endpackage

// *** rtl/wake_filter_control_status.sv ***
// wake filter enables, sticky wake causes and station address behind the paged management port
`timescale 1ns/1ps
`default_nettype none
`include "wake_defines.svh"

module wake_filter_control_status (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic phy_rst,
  input wire logic mgmt_valid,
  input wire wake_pkg::mgmt_req_t mgmt_req,
  output logic mgmt_ack,
  output logic [15:0] mgmt_rdata,
  input wire logic wake_active_clear,
  output logic [15:0] wake_cause_status,
  output logic [15:0] wake_filter_enable,
  output logic power_event_flag,
  input wire logic rx_clk,
  input wire logic rx_event_valid,
  input wire wake_pkg::rx_event_t rx_event,
  output logic rx_event_ready
);

  // ****************************************************
  // receive side: capture one event and hand it over
  // ****************************************************
  // a toggle handshake carries the event word; the word is held stable
  // until the ack returns, so events arriving meanwhile are refused
  wake_pkg::rx_event_t lk_data_q;
  wake_pkg::rx_event_t lk_data_d;
  logic lk_req_q;
  logic lk_req_d;
  logic lk_ack_s1_q;
  logic lk_ack_s2_q;
  logic lk_ready_q;
  logic lk_ready_d;
  // the ack toggle lives in the reference domain and is only read here
  // through the two-stage synchroniser below
  logic ev_ack_q;

  always_comb begin
    lk_data_d = lk_data_q;
    lk_req_d = lk_req_q;
    if (rx_event_valid && (lk_req_q == lk_ack_s2_q)) begin
      lk_data_d = rx_event;
      lk_req_d = ~lk_req_q;
    end
    lk_ready_d = (lk_req_d == lk_ack_s2_q);
  end

  always_ff @(posedge rx_clk or negedge rst_n) begin
    if (!rst_n) begin
      lk_data_q <= '0;
      lk_req_q <= 1'b0;
      lk_ack_s1_q <= 1'b0;
      lk_ack_s2_q <= 1'b0;
      lk_ready_q <= 1'b0;
    end else begin
      lk_data_q <= lk_data_d;
      lk_req_q <= lk_req_d;
      lk_ack_s1_q <= ev_ack_q;
      lk_ack_s2_q <= lk_ack_s1_q;
      lk_ready_q <= lk_ready_d;
    end
  end

  assign rx_event_ready = lk_ready_q;

  // ****************************************************
  // reference side: handshake receiver
  // ****************************************************
  logic ev_req_s1_q;
  logic ev_req_s2_q;
  logic ev_ack_d;
  logic ev_take;
  wake_pkg::rx_event_t ev_word;

  always_comb begin
    ev_take = (ev_req_s2_q != ev_ack_q);
    ev_ack_d = ev_req_s2_q;
    ev_word = lk_data_q;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ev_req_s1_q <= 1'b0;
      ev_req_s2_q <= 1'b0;
      ev_ack_q <= 1'b0;
    end else if (clk_en) begin
      ev_req_s1_q <= lk_req_q;
      ev_req_s2_q <= ev_req_s1_q;
      ev_ack_q <= ev_ack_d;
    end
  end

  // ****************************************************
  // register state
  // ****************************************************
  logic [15:0] page_q;
  logic [15:0] page_d;
  logic [15:0] register_number_field_q;
  logic [15:0] register_number_field_d;
  logic [15:0] ctrl_q;
  logic [15:0] ctrl_d;
  logic [15:0] enable_q;
  logic [15:0] enable_d;
  logic [15:0] status_q;
  logic [15:0] status_d;
  logic [31:0] addr_low_q;
  logic [31:0] addr_low_d;
  logic [15:0] addr_high_lo_q;
  logic [15:0] addr_high_lo_d;
  logic addr_valid_q;
  logic addr_valid_d;
  logic ack_q;
  logic ack_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  // ****************************************************
  // wake qualification
  // ****************************************************
  logic [15:0] cause_enable;
  logic [15:0] cause_match;
  logic [15:0] cause_set;
  logic link_enable;
  logic host_blocked;

  always_comb begin
    // fixed causes share positions between enable and status
    cause_enable = '0;
    cause_enable[`DIRECTED_IPV6_WAKE:`MAGIC_PACKET_WAKE] =
      enable_q[`DIRECTED_IPV6_WAKE:`MAGIC_PACKET_WAKE];
    // flexible 4 and 5 sit at enable 10:9 but status 9:8
    cause_enable[`STATUS_FLEX_4+1:`STATUS_FLEX_4] =
      enable_q[`FLEXIBLE_FILTER_5:`FLEXIBLE_FILTER_4];
    cause_enable[`STATUS_FLEX_6+1:`STATUS_FLEX_6] =
      ctrl_q[`CTRL_FLEXIBLE_FILTER_6+1:`CTRL_FLEXIBLE_FILTER_6];
    cause_enable[`STATUS_FLEX_0+3:`STATUS_FLEX_0] =
      enable_q[`FLEXIBLE_FILTER_0+3:`FLEXIBLE_FILTER_0];
    if (ctrl_q[`LINK_WAKE_OVERRIDE]) begin
      link_enable = ctrl_q[`CTRL_APM_ENABLE] & ctrl_q[`CTRL_LINK_WAKE_ENABLE];
    end else begin
      link_enable = enable_q[`LINK_CHANGE_WAKE];
    end
    cause_enable[`LINK_CHANGE_WAKE] = link_enable;
    // the engine reports exact, hash and table matches; the station
    // address compare is done here and only while it is marked valid
    cause_match = ev_word.match;
    if (addr_valid_q && (ev_word.dest_addr == {addr_high_lo_q, addr_low_q})) begin
      cause_match[`EXACT_MATCH_WAKE] = 1'b1;
    end
    host_blocked = enable_q[`IGNORE_MANAGEABILITY_PACKETS] & ev_word.manageability;
    if (ev_take && !host_blocked) begin
      cause_set = cause_match & cause_enable;
    end else begin
      cause_set = '0;
    end
  end

  // ****************************************************
  // read mux
  // ****************************************************
  function automatic logic [15:0] read_word(input logic [15:0] idx);
    logic [15:0] word;
    word = `ZERO_WORD;
    unique case (idx)
      `WAKE_CONTROL_IDX: word = ctrl_q;
      `WAKE_FILTER_ENABLE_IDX: word = enable_q;
      `WAKE_CAUSE_STATUS_IDX: word = status_q;
      `STATION_LOW_LO_IDX: word = addr_low_q[15:0];
      `STATION_LOW_HI_IDX: word = addr_low_q[31:16];
      `STATION_HIGH_LO_IDX: word = addr_high_lo_q;
      // bits 30:16 of the high word are never stored and read zero
      `STATION_HIGH_HI_IDX: word = {addr_valid_q, 15'h0000};
      default: word = `ZERO_WORD;
    endcase
    return word;
  endfunction

  // ****************************************************
  // management access and register update
  // ****************************************************
  logic data_access;
  logic data_write;
  logic [15:0] w1c_status;
  logic ctrl_flag_clear;

  always_comb begin
    page_d = page_q;
    register_number_field_d = register_number_field_q;
    ctrl_d = ctrl_q;
    enable_d = enable_q;
    addr_low_d = addr_low_q;
    addr_high_lo_d = addr_high_lo_q;
    addr_valid_d = addr_valid_q;
    ack_d = 1'b0;
    rdata_d = rdata_q;
    w1c_status = '0;
    ctrl_flag_clear = 1'b0;
    // data cycles only reach the wake page once it is selected
    data_access = mgmt_valid && (mgmt_req.reg_num == `MGMT_REG_DATA_REG) &&
                  (page_q == `WAKE_PAGE_NUMBER);
    data_write = data_access && mgmt_req.write;
    if (mgmt_valid) begin
      ack_d = 1'b1;
      rdata_d = `ZERO_WORD;
      if (mgmt_req.reg_num == `MGMT_PAGE_SELECT_REG) begin
        if (mgmt_req.write) begin
          page_d = mgmt_req.wdata;
        end else begin
          rdata_d = page_q;
        end
      end else if (mgmt_req.reg_num == `MGMT_REG_NUMBER_REG) begin
        if (mgmt_req.write) begin
          register_number_field_d = mgmt_req.wdata;
        end else begin
          rdata_d = register_number_field_q;
        end
      end else if (data_access && !mgmt_req.write) begin
        rdata_d = read_word(register_number_field_q);
      end
    end
    if (data_write) begin
      unique case (register_number_field_q)
        `WAKE_CONTROL_IDX: begin
          ctrl_d = (ctrl_q & ~`CTRL_STORE_MASK) | (mgmt_req.wdata & `CTRL_STORE_MASK);
          ctrl_flag_clear = mgmt_req.wdata[`POWER_EVENT_FLAG];
        end
        `WAKE_FILTER_ENABLE_IDX: begin
          enable_d = mgmt_req.wdata & `FILTER_ENABLE_WRITE_MASK;
        end
        `WAKE_CAUSE_STATUS_IDX: begin
          w1c_status = mgmt_req.wdata;
        end
        `STATION_LOW_LO_IDX: begin
          addr_low_d[15:0] = mgmt_req.wdata;
        end
        `STATION_LOW_HI_IDX: begin
          addr_low_d[31:16] = mgmt_req.wdata;
        end
        `STATION_HIGH_LO_IDX: begin
          addr_high_lo_d = mgmt_req.wdata;
        end
        `STATION_HIGH_HI_IDX: begin
          addr_valid_d = mgmt_req.wdata[`ADDRESS_COMPARE_VALID];
        end
        default: begin
          ctrl_d = ctrl_q;
        end
      endcase
    end
    // a cause arriving with its own clear is kept: set wins
    status_d = (status_q & ~w1c_status) | cause_set;
    if (|cause_set) begin
      ctrl_d[`POWER_EVENT_FLAG] = 1'b1;
    end else if (ctrl_flag_clear || wake_active_clear) begin
      ctrl_d[`POWER_EVENT_FLAG] = 1'b0;
    end
    // phy reset only drops the access path, never the wake page itself
    if (phy_rst) begin
      page_d = `ZERO_WORD;
      register_number_field_d = `ZERO_WORD;
    end
  end

  // only the power-on reset reaches the wake page registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      page_q <= `ZERO_WORD;
      register_number_field_q <= `ZERO_WORD;
      ctrl_q <= `ZERO_WORD;
      enable_q <= `ZERO_WORD;
      status_q <= `ZERO_WORD;
      addr_low_q <= {`ZERO_WORD, `ZERO_WORD};
      addr_high_lo_q <= `ZERO_WORD;
      addr_valid_q <= 1'b0;
      ack_q <= 1'b0;
      rdata_q <= `ZERO_WORD;
    end else if (clk_en) begin
      page_q <= page_d;
      register_number_field_q <= register_number_field_d;
      ctrl_q <= ctrl_d;
      enable_q <= enable_d;
      status_q <= status_d;
      addr_low_q <= addr_low_d;
      addr_high_lo_q <= addr_high_lo_d;
      addr_valid_q <= addr_valid_d;
      ack_q <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  assign mgmt_ack = ack_q;
  assign mgmt_rdata = rdata_q;
  assign wake_cause_status = status_q;
  assign wake_filter_enable = enable_q;
  assign power_event_flag = ctrl_q[`POWER_EVENT_FLAG];

endmodule
`default_nettype wire

// *** dv/wake_props.sv ***
// concurrent checks on the ports of the wake register block
`timescale 1ns/1ps
`default_nettype none
module wake_props (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic mgmt_valid,
  input wire wake_pkg::mgmt_req_t mgmt_req,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  input wire logic wake_active_clear,
  input wire logic [15:0] wake_cause_status,
  input wire logic [15:0] wake_filter_enable,
  input wire logic power_event_flag,
  input wire logic rx_clk,
  input wire logic rx_event_valid,
  input wire logic rx_event_ready
);
  logic [15:0] prev_q;
  logic [15:0] rise;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) prev_q <= 16'h0000;
    else prev_q <= wake_cause_status;
  end
  assign rise = wake_cause_status & ~prev_q;
  property p_ack;
    @(posedge ref_clk) disable iff (!rst_n) mgmt_valid |=> mgmt_ack;
  endproperty
  a_ack: assert property (p_ack) else $error("no ack after request");
  property p_ack_src;
    @(posedge ref_clk) disable iff (!rst_n) mgmt_ack |-> $past(mgmt_valid);
  endproperty
  a_ack_src: assert property (p_ack_src) else $error("ack without request");
  property p_wr_zero;
    @(posedge ref_clk) disable iff (!rst_n)
      mgmt_ack && $past(mgmt_req.write) |-> mgmt_rdata == 16'h0000;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write answered nonzero");
  property p_rsvd;
    @(posedge ref_clk) disable iff (!rst_n) wake_filter_enable[8] == 1'b0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved enable bit set");
  property p_fall;
    @(posedge ref_clk) disable iff (!rst_n)
      (($past(wake_cause_status) & ~wake_cause_status) != 16'h0000)
      |-> $past(mgmt_valid && mgmt_req.write);
  endproperty
  a_fall: assert property (p_fall) else $error("status fell without write");
  // flex 6/7 enables live in the control register, and so does the link change enable while the override bit is set
  property p_rise_en;
    @(posedge ref_clk) disable iff (!rst_n)
      rise != 16'h0000 |-> (rise & ~{$past(wake_filter_enable[15:12]), 2'b00,
        $past(wake_filter_enable[10:9]), $past(wake_filter_enable[7:1]), 1'b0}
        & 16'hF3FE) == 16'h0000;
  endproperty
  a_rise_en: assert property (p_rise_en) else $error("status set while disabled");
  property p_pef;
    @(posedge ref_clk) disable iff (!rst_n) rise != 16'h0000 |-> power_event_flag;
  endproperty
  a_pef: assert property (p_pef) else $error("wake without power flag");
  property p_pef_hold;
    @(posedge ref_clk) disable iff (!rst_n)
      power_event_flag && !wake_active_clear && !(mgmt_valid && mgmt_req.write)
      |=> power_event_flag;
  endproperty
  a_pef_hold: assert property (p_pef_hold) else $error("power flag lost");
  property p_busy;
    @(posedge rx_clk) disable iff (!rst_n) rx_event_valid && rx_event_ready |=> !rx_event_ready;
  endproperty
  a_busy: assert property (p_busy) else $error("ready stayed high after take");
  property p_back;
    @(posedge rx_clk) disable iff (!rst_n) $fell(rx_event_ready) |-> ##[1:40] rx_event_ready;
  endproperty
  a_back: assert property (p_back) else $error("ready did not return");
  c_take: cover property (@(posedge rx_clk) disable iff (!rst_n) rx_event_valid && rx_event_ready);
  c_rise: cover property (@(posedge ref_clk) disable iff (!rst_n) rise != 16'h0000);
  c_clr: cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(power_event_flag));
endmodule
bind wake_filter_control_status wake_props wake_props_i (.ref_clk(ref_clk), .rst_n(rst_n),
  .mgmt_valid(mgmt_valid), .mgmt_req(mgmt_req), .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata),
  .wake_active_clear(wake_active_clear), .wake_cause_status(wake_cause_status),
  .wake_filter_enable(wake_filter_enable), .power_event_flag(power_event_flag),
  .rx_clk(rx_clk), .rx_event_valid(rx_event_valid), .rx_event_ready(rx_event_ready));
`default_nettype wire

// *** dv/lan_ctrl_model.sv ***
// management master and event source standing in for the lan controller
`timescale 1ns/1ps
`default_nettype none
`include "wake_defines.svh"
module lan_ctrl_model (
  input wire logic ref_clk,
  input wire logic rx_clk,
  input wire logic mgmt_ack,
  input wire logic [15:0] mgmt_rdata,
  input wire logic rx_event_ready,
  output var logic mgmt_valid,
  output var wake_pkg::mgmt_req_t mgmt_req,
  output var logic rx_event_valid,
  output var wake_pkg::rx_event_t rx_event
);
  initial begin
    mgmt_valid = 1'b0;
    mgmt_req = '0;
    rx_event_valid = 1'b0;
    rx_event = '0;
  end
  // released lines show the inverse so stale values never pass as fresh
  task automatic acc(input logic w, input logic [4:0] n, input logic [15:0] d,
                     output logic [15:0] r);
    int k;
    @(posedge ref_clk);
    mgmt_valid <= 1'b1;
    mgmt_req <= '{w, n, d};
    @(posedge ref_clk);
    mgmt_valid <= 1'b0;
    mgmt_req <= ~mgmt_req;
    for (k = 0; k < 4; k++) begin
      #1;
      if (mgmt_ack === 1'b1) break;
      @(posedge ref_clk);
    end
    if (k == 4) tb.hang();
    r = mgmt_rdata;
  endtask
  task automatic wreg(input logic [15:0] n, input logic [15:0] d);
    logic [15:0] r;
    acc(1'b1, `MGMT_PAGE_SELECT_REG, `WAKE_PAGE_NUMBER, r);
    acc(1'b1, `MGMT_REG_NUMBER_REG, n, r);
    acc(1'b1, `MGMT_REG_DATA_REG, d, r);
  endtask
  task automatic rreg(input logic [15:0] n, output logic [15:0] r);
    acc(1'b1, `MGMT_PAGE_SELECT_REG, `WAKE_PAGE_NUMBER, r);
    acc(1'b1, `MGMT_REG_NUMBER_REG, n, r);
    acc(1'b0, `MGMT_REG_DATA_REG, 16'h0000, r);
  endtask
  task automatic send_event(input wake_pkg::rx_event_t e);
    int k;
    k = 0;
    while (rx_event_ready !== 1'b1 && k < 40) begin
      @(posedge rx_clk);
      #1;
      k++;
    end
    @(posedge rx_clk);
    rx_event_valid <= 1'b1;
    rx_event <= e;
    @(posedge rx_clk);
    rx_event_valid <= 1'b0;
    rx_event <= ~e;
    #1;
    while (rx_event_ready !== 1'b1 && k < 80) begin
      @(posedge rx_clk);
      #1;
      k++;
    end
    if (k >= 80) tb.hang();
    repeat (2) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

// *** dv/tb.sv ***
// self-checking bench for the wake filter control and status block
`timescale 1ns/1ps
`default_nettype none
`include "wake_defines.svh"
`define CHK(nm, e, g) cmp(nm, e, g)
module tb;
  logic ref_clk, rx_clk, rst_n, clk_en, phy_rst, wake_active_clear;
  logic mgmt_valid, mgmt_ack, power_event_flag, rx_event_valid, rx_event_ready;
  logic [15:0] mgmt_rdata, wake_cause_status, wake_filter_enable;
  wake_pkg::mgmt_req_t mgmt_req;
  wake_pkg::rx_event_t rx_event;
  int num_errors = 0;
  int total_checks = 0;
  wake_filter_control_status wake_filter_control_status_i (.ref_clk(ref_clk), .rst_n(rst_n),
    .clk_en(clk_en), .phy_rst(phy_rst), .mgmt_valid(mgmt_valid), .mgmt_req(mgmt_req),
    .mgmt_ack(mgmt_ack), .mgmt_rdata(mgmt_rdata), .wake_active_clear(wake_active_clear),
    .wake_cause_status(wake_cause_status), .wake_filter_enable(wake_filter_enable),
    .power_event_flag(power_event_flag), .rx_clk(rx_clk), .rx_event_valid(rx_event_valid),
    .rx_event(rx_event), .rx_event_ready(rx_event_ready));
  lan_ctrl_model lan_ctrl_model_i (.ref_clk(ref_clk), .rx_clk(rx_clk), .mgmt_ack(mgmt_ack),
    .mgmt_rdata(mgmt_rdata), .rx_event_ready(rx_event_ready), .mgmt_valid(mgmt_valid),
    .mgmt_req(mgmt_req), .rx_event_valid(rx_event_valid), .rx_event(rx_event));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    rx_clk = 1'b0;
    #1.7;
    forever #3 rx_clk = ~rx_clk;
  end
  task automatic conclude();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic hang();
    num_errors++;
    conclude();
  endtask
  task automatic cmp(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_st(input logic [15:0] e);
    logic [15:0] r;
    lan_ctrl_model_i.rreg(`WAKE_CAUSE_STATUS_IDX, r);
    `CHK("status reg", e, r);
    `CHK("status port", e, wake_cause_status);
  endtask
  task automatic t_reset();
    logic [15:0] r;
    logic [15:0] idx [6] = '{16'h0002, 16'h0003, 16'h0010, 16'h0011, 16'h0012, 16'h0013};
    for (int i = 0; i < 6; i++) begin
      lan_ctrl_model_i.rreg(idx[i], r);
      `CHK("reset value", 16'h0000, r);
    end
  endtask
  task automatic t_enable();
    logic [15:0] r;
    for (int i = 0; i < 16; i++) begin
      lan_ctrl_model_i.wreg(16'h0002, 16'h0001 << i);
      lan_ctrl_model_i.rreg(16'h0002, r);
      `CHK("enable reg", (16'h0001 << i) & 16'hFEFF, r);
      `CHK("enable port", (16'h0001 << i) & 16'hFEFF, wake_filter_enable);
    end
  endtask
  task automatic t_station();
    logic [15:0] r;
    logic [15:0] wv [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hFFFF};
    logic [15:0] xv [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'h8000};
    for (int i = 0; i < 4; i++) lan_ctrl_model_i.wreg(16'h0010 + i, wv[i]);
    for (int i = 0; i < 4; i++) begin
      lan_ctrl_model_i.rreg(16'h0010 + i, r);
      `CHK("station", xv[i], r);
    end
    lan_ctrl_model_i.rreg(16'h0005, r);
    `CHK("unmapped", 16'h0000, r);
  endtask
  task automatic t_wake();
    lan_ctrl_model_i.wreg(16'h0002, 16'hF2F6);
    lan_ctrl_model_i.send_event('{48'h0000_0000_0000, 1'b0, 16'hFFFF});
    // flexible 4 enable at bit 9 lands in status bit 8; bit 0 and 10/11 stay off
    chk_st(16'hF1F6);
    `CHK("power flag", 16'h0001, {15'h0000, power_event_flag});
    lan_ctrl_model_i.wreg(16'h0003, 16'h00F0);
    chk_st(16'hF106);
    @(posedge ref_clk);
    wake_active_clear <= 1'b1;
    @(posedge ref_clk);
    wake_active_clear <= 1'b0;
    #1;
    `CHK("power flag", 16'h0000, {15'h0000, power_event_flag});
    lan_ctrl_model_i.wreg(16'h0003, 16'hFFFF);
    chk_st(16'h0000);
  endtask
  task automatic t_causes();
    lan_ctrl_model_i.wreg(16'h0002, 16'h0812);
    lan_ctrl_model_i.send_event('{48'h0000_0000_0000, 1'b1, 16'h0012});
    chk_st(16'h0000);
    lan_ctrl_model_i.send_event('{48'h0000_0000_0000, 1'b0, 16'h0013});
    chk_st(16'h0012);
    lan_ctrl_model_i.wreg(16'h0001, 16'h0031);
    lan_ctrl_model_i.send_event('{48'h0000_0000_0000, 1'b0, 16'h0001});
    chk_st(16'h0013);
    lan_ctrl_model_i.wreg(16'h0001, 16'h0000);
    lan_ctrl_model_i.wreg(16'h0003, 16'hFFFF);
  endtask
  task automatic t_exact();
    logic [15:0] r;
    lan_ctrl_model_i.wreg(16'h0002, 16'h0004);
    lan_ctrl_model_i.send_event('{48'h9ABC_5678_1234, 1'b0, 16'h0000});
    chk_st(16'h0004);
    @(posedge ref_clk);
    phy_rst <= 1'b1;
    @(posedge ref_clk);
    phy_rst <= 1'b0;
    // page select is lost on phy reset, so the data register answers zero
    lan_ctrl_model_i.acc(1'b0, `MGMT_REG_DATA_REG, 16'h0000, r);
    `CHK("page lost", 16'h0000, r);
    chk_st(16'h0004);
    lan_ctrl_model_i.wreg(16'h0003, 16'hFFFF);
    lan_ctrl_model_i.wreg(16'h0013, 16'h0000);
    lan_ctrl_model_i.send_event('{48'h9ABC_5678_1234, 1'b0, 16'h0000});
    chk_st(16'h0000);
  endtask
  initial begin
    rst_n = 1'b0;
    clk_en = 1'b1;
    phy_rst = 1'b0;
    wake_active_clear = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_enable();
    t_station();
    t_wake();
    t_causes();
    t_exact();
    conclude();
  end
endmodule
`default_nettype wire
